// File: dics_defs.svh
// Constants of the interrupt, context and return-stack unit.
// Definitions only; included by the package and by the unit.
`ifndef DICS_DEFS_SVH
`define DICS_DEFS_SVH
// ******************************
// Sizes
// ******************************
`define DICS_STACK_DEPTH 8
`define DICS_NUM_VEC 32
`define DICS_RSVD_VEC 5'h14
`define DICS_NUM_SRC 7
`define DICS_NUM_USER 4
// ******************************
// Pending flag positions
// ******************************
`define DICS_SRC_USER 0
`define DICS_SRC_TIMER 4
`define DICS_SRC_SERIAL 5
// ******************************
// Vector numbers
// ******************************
`define DICS_VEC_USER 5'h01
`define DICS_VEC_TIMER 5'h05
`define DICS_VEC_SERIAL 5'h06
`define DICS_VEC_TRAP 5'h11
`define DICS_VEC_NMI 5'h12
// ******************************
// Condition select bits
// ******************************
`define DICS_NUM_COND 13
`define DICS_C_EQ 0
`define DICS_C_NEQ 1
`define DICS_C_LT 2
`define DICS_C_LEQ 3
`define DICS_C_GT 4
`define DICS_C_GEQ 5
`define DICS_C_NC 6
`define DICS_C_C 7
`define DICS_C_NOV 8
`define DICS_C_OV 9
`define DICS_C_BIO 10
`define DICS_C_NTC 11
`define DICS_C_TC 12
// ******************************
// Reset values
// ******************************
`define DICS_GID_RST 1'h1
`define DICS_PTR_RST 5'h00
`endif

// File: dics_pkg.sv
// Types shared by the unit and its surroundings.
// Assumes dics_defs.svh is on the include path.
`include "dics_defs.svh"
package dics_pkg;
	// Commands issued by the instruction sequencer
	typedef enum logic [4:0] {
		CMD_NOP, CMD_CALL, CMD_RET, CMD_COND_CALL, CMD_COND_RET,
		CMD_COND_EXEC, CMD_COND_BRANCH, CMD_PUSH_SUM, CMD_POP_SUM,
		CMD_MEM_TO_STACK, CMD_STACK_TO_MEM, CMD_SOFT_VECTOR, CMD_TRAP,
		CMD_NMI_TRIGGER, CMD_IRQ_RET, CMD_IRQ_RET_EN, CMD_KEEP_LARGER,
		CMD_REPEAT_ONE, CMD_REPEAT_BLOCK, CMD_SET_DISABLE,
		CMD_CLR_DISABLE, CMD_LOAD_VEC_PTR
	} dics_cmd_t;
endpackage

// File: dics_exception_unit.sv
// Interrupt, context-save and return-stack unit of the core.
// Assumes one sequencer command per cycle on clk; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "dics_defs.svh"
module dics_exception_unit #(
	parameter int StackDepth = `DICS_STACK_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// External request pins
	input wire logic [`DICS_NUM_USER-1:0] userIrqLines,
	input wire logic nmiReq,
	// Internal sources and masks
	input wire logic [1:0] serialIrq,
	input wire logic timerIrq,
	input wire logic [`DICS_NUM_SRC-1:0] irqMask,
	// Sequencer command
	input wire logic cmdValid,
	input wire dics_pkg::dics_cmd_t cmd,
	input wire logic [15:0] cmdArg,
	input wire logic [`DICS_NUM_COND-1:0] condSel,
	input wire logic [15:0] nextPc,
	input wire logic [15:0] curPc,
	input wire logic execDone,
	input wire logic [15:0] memData,
	input wire logic [15:0] blockRepeatCount,
	// Core flags
	input wire logic carryIn,
	input wire logic overflowIn,
	input wire logic testFlagIn,
	input wire logic bioIn,
	// Live working registers
	input wire logic [31:0] ctxSum,
	input wire logic [31:0] ctxSumBuf,
	input wire logic [31:0] ctxProduct,
	input wire logic [15:0] ctxStatus0,
	input wire logic [15:0] ctxStatus1,
	input wire logic [15:0] ctxMode,
	input wire logic [15:0] ctxMulTemp,
	input wire logic [15:0] ctxShiftTemp,
	input wire logic [15:0] ctxBitTemp,
	input wire logic [15:0] ctxIndex,
	input wire logic [15:0] ctxCompare,
	// Trap entry
	output logic trapTaken,
	output logic [4:0] trapVector,
	output logic [15:0] trapAddr,
	output logic trapUserVector,
	output logic globalIrqDisable,
	output logic [`DICS_NUM_SRC-1:0] pendingFlags,
	// Program flow
	output logic pcLoadValid,
	output logic [15:0] pcLoadAddr,
	output logic condTrue,
	output logic repeatActive,
	output logic blockActive,
	// Stack
	output logic [15:0] stackTop,
	output logic [$clog2(StackDepth+1)-1:0] stackLevel,
	output logic stackOutValid,
	output logic [15:0] stackOutData,
	// Keep-larger result
	output logic largerValid,
	output logic [31:0] largerValue,
	output logic largerCarry,
	// Shadow copies
	output logic restoreValid,
	output logic [31:0] shadowSum,
	output logic [31:0] shadowSumBuf,
	output logic [31:0] shadowProduct,
	output logic [15:0] shadowStatus0,
	output logic [15:0] shadowStatus1,
	output logic [15:0] shadowMode,
	output logic [15:0] shadowMulTemp,
	output logic [15:0] shadowShiftTemp,
	output logic [15:0] shadowBitTemp,
	output logic [15:0] shadowIndex,
	output logic [15:0] shadowCompare
);
	import dics_pkg::*;
	localparam int LvlW = $clog2(StackDepth+1);

	// ******************************
	// State
	// ******************************
	logic [3:0] uS1_reg, uS1_next, uS2_reg, uS2_next, uS3_reg, uS3_next;
	logic nS1_reg, nS1_next, nS2_reg, nS2_next, nS3_reg, nS3_next;
	logic [`DICS_NUM_SRC-1:0] pend_reg, pend_next;
	logic nmiPend_reg, nmiPend_next, gid_reg, gid_next;
	logic [4:0] vecPtr_reg, vecPtr_next;
	logic [15:0] stack_reg [StackDepth], stack_next [StackDepth];
	logic [LvlW-1:0] lvl_reg, lvl_next;
	logic rptActive_reg, rptActive_next, blkActive_reg, blkActive_next;
	logic [15:0] rptCount_reg, rptCount_next, blkCount_reg, blkCount_next;
	logic [15:0] blkStart_reg, blkStart_next, blkEnd_reg, blkEnd_next;
	logic trap_reg, trap_next, tUser_reg, tUser_next;
	logic [4:0] tVec_reg, tVec_next;
	logic [15:0] tAddr_reg, tAddr_next, pcAddr_reg, pcAddr_next;
	logic pcLd_reg, pcLd_next, cond_reg, cond_next;
	logic sOut_reg, sOut_next, lgV_reg, lgV_next, lgC_reg, lgC_next;
	logic [15:0] sData_reg, sData_next;
	logic [31:0] lgVal_reg, lgVal_next;
	logic rest_reg, rest_next;
	logic [31:0] shW_reg [3], shW_next [3];
	logic [15:0] shN_reg [8], shN_next [8];

	// Scratch of the next-state process
	logic [`DICS_NUM_COND-1:0] condVec;
	logic [`DICS_NUM_SRC-1:0] live, masked, hwClr;
	logic condOk, takeAny, doPush, doPop, nmiClr;
	logic [4:0] hwVec, takeVec;
	logic [15:0] pushVal;

	// Vector number of a pending flag position
	function automatic logic [4:0] srcVec(input int s);
		if (s < `DICS_SRC_TIMER) srcVec = `DICS_VEC_USER + 5'(s);
		else if (s == `DICS_SRC_TIMER) srcVec = `DICS_VEC_TIMER;
		else srcVec = `DICS_VEC_SERIAL + 5'(s - `DICS_SRC_SERIAL);
	endfunction

	// ******************************
	// Next-state logic
	// ******************************
	always_comb begin
		condVec = '0;
		live = '0;
		masked = '0;
		hwClr = '0;
		condOk = 1'b0;
		takeAny = 1'b0;
		doPush = 1'b0;
		doPop = 1'b0;
		nmiClr = 1'b0;
		hwVec = `DICS_VEC_USER;
		takeVec = `DICS_VEC_TRAP;
		pushVal = nextPc;
		{uS1_next, uS2_next, uS3_next} = {userIrqLines, uS1_reg, uS2_reg};
		{nS1_next, nS2_next, nS3_next} = {nmiReq, nS1_reg, nS2_reg};
		pend_next = pend_reg;
		nmiPend_next = nmiPend_reg;
		gid_next = gid_reg;
		vecPtr_next = vecPtr_reg;
		stack_next = stack_reg;
		lvl_next = lvl_reg;
		rptActive_next = rptActive_reg;
		rptCount_next = rptCount_reg;
		blkActive_next = blkActive_reg;
		blkCount_next = blkCount_reg;
		blkStart_next = blkStart_reg;
		blkEnd_next = blkEnd_reg;
		trap_next = 1'b0;
		tVec_next = tVec_reg;
		tAddr_next = tAddr_reg;
		tUser_next = tUser_reg;
		pcLd_next = 1'b0;
		pcAddr_next = pcAddr_reg;
		cond_next = cond_reg;
		sOut_next = 1'b0;
		sData_next = sData_reg;
		lgV_next = 1'b0;
		lgVal_next = lgVal_reg;
		lgC_next = lgC_reg;
		rest_next = 1'b0;
		shW_next = shW_reg;
		shN_next = shN_reg;
		// Rising edges on the pins, timer and serial levels raise requests
		live = {serialIrq, timerIrq, uS2_reg & ~uS3_reg};
		masked = pend_reg & irqMask;
		// Lowest flag position has the highest priority
		for (int i = `DICS_NUM_SRC - 1; i >= 0; i--) begin
			if (masked[i]) begin
				hwVec = srcVec(i);
				hwClr = '0;
				hwClr[i] = 1'b1;
			end
		end
		// Thirteen conditions, all selected ones must hold
		condVec[`DICS_C_EQ] = ctxSum == 32'h0;
		condVec[`DICS_C_NEQ] = ctxSum != 32'h0;
		condVec[`DICS_C_LT] = ctxSum[31];
		condVec[`DICS_C_LEQ] = ctxSum[31] || ctxSum == 32'h0;
		condVec[`DICS_C_GT] = !ctxSum[31] && ctxSum != 32'h0;
		condVec[`DICS_C_GEQ] = !ctxSum[31];
		condVec[`DICS_C_NC] = !carryIn;
		condVec[`DICS_C_C] = carryIn;
		condVec[`DICS_C_NOV] = !overflowIn;
		condVec[`DICS_C_OV] = overflowIn;
		condVec[`DICS_C_BIO] = bioIn;
		condVec[`DICS_C_NTC] = !testFlagIn;
		condVec[`DICS_C_TC] = testFlagIn;
		condOk = &(condVec | ~condSel);
		// Hardware requests are taken only between instructions
		if (!cmdValid && !rptActive_reg) begin
			if (nmiPend_reg) begin
				takeAny = 1'b1;
				takeVec = `DICS_VEC_NMI;
				nmiClr = 1'b1;
			end else if (!gid_reg && |masked) begin
				takeAny = 1'b1;
				takeVec = hwVec;
			end
		end
		if (cmdValid) begin
			case (cmd)
				CMD_CALL, CMD_COND_CALL: begin
					if (cmd == CMD_CALL || condOk) begin
						doPush = 1'b1;
						pcLd_next = 1'b1;
						pcAddr_next = cmdArg;
					end
				end
				CMD_RET, CMD_COND_RET: begin
					if (cmd == CMD_RET || condOk) begin
						doPop = 1'b1;
						pcLd_next = 1'b1;
						pcAddr_next = stack_reg[0];
					end
				end
				CMD_COND_EXEC: cond_next = condOk;
				CMD_COND_BRANCH: begin
					cond_next = condOk;
					pcLd_next = condOk;
					pcAddr_next = cmdArg;
				end
				CMD_PUSH_SUM: begin
					doPush = 1'b1;
					pushVal = ctxSum[15:0];
				end
				CMD_MEM_TO_STACK: begin
					doPush = 1'b1;
					pushVal = memData;
				end
				CMD_POP_SUM, CMD_STACK_TO_MEM: begin
					doPop = 1'b1;
					sOut_next = 1'b1;
					sData_next = stack_reg[0];
				end
				CMD_SOFT_VECTOR: begin
					takeAny = 1'b1;
					takeVec = cmdArg[4:0];
				end
				CMD_TRAP: takeAny = 1'b1;
				CMD_NMI_TRIGGER: begin
					takeAny = 1'b1;
					takeVec = `DICS_VEC_NMI;
				end
				CMD_IRQ_RET, CMD_IRQ_RET_EN: begin
					doPop = 1'b1;
					pcLd_next = 1'b1;
					pcAddr_next = stack_reg[0];
					rest_next = 1'b1;
					if (cmd == CMD_IRQ_RET_EN) gid_next = 1'b0;
				end
				CMD_KEEP_LARGER: begin
					lgV_next = 1'b1;
					lgC_next = $signed(ctxSum) > $signed(ctxSumBuf);
					lgVal_next = lgC_next ? ctxSum : ctxSumBuf;
				end
				CMD_REPEAT_ONE: begin
					rptActive_next = 1'b1;
					rptCount_next = cmdArg;
				end
				CMD_REPEAT_BLOCK: begin
					blkActive_next = 1'b1;
					blkCount_next = blockRepeatCount;
					blkStart_next = nextPc;
					blkEnd_next = cmdArg;
				end
				CMD_SET_DISABLE: gid_next = 1'b1;
				CMD_CLR_DISABLE: gid_next = 1'b0;
				CMD_LOAD_VEC_PTR: vecPtr_next = cmdArg[4:0];
				default: ;
			endcase
		end
		// Single repeat: count N gives N plus one runs of the next instruction
		if (execDone && rptActive_reg) begin
			if (rptCount_reg == 16'h0) rptActive_next = 1'b0;
			else rptCount_next = rptCount_reg - 16'h1;
		end
		// Block end reached: loop back while the count is not exhausted
		if (execDone && blkActive_reg && curPc == blkEnd_reg) begin
			if (blkCount_reg == 16'h0) begin
				blkActive_next = 1'b0;
			end else begin
				blkCount_next = blkCount_reg - 16'h1;
				pcLd_next = 1'b1;
				pcAddr_next = blkStart_reg;
			end
		end
		// Trap entry: vector, return address, shadow copy, disable
		if (takeAny) begin
			doPush = 1'b1;
			pushVal = nextPc;
			gid_next = 1'b1;
			trap_next = 1'b1;
			tVec_next = takeVec;
			tAddr_next = {vecPtr_reg, 5'h00, takeVec, 1'b0};
			tUser_next = takeVec >= `DICS_RSVD_VEC;
			shW_next = '{ctxSum, ctxSumBuf, ctxProduct};
			shN_next = '{ctxStatus0, ctxStatus1, ctxMode, ctxMulTemp,
				ctxShiftTemp, ctxBitTemp, ctxIndex, ctxCompare};
		end
		// Stack as a shift register; overflow drops the bottom entry
		if (doPush) begin
			for (int i = StackDepth - 1; i > 0; i--) stack_next[i] = stack_reg[i-1];
			stack_next[0] = pushVal;
			if (lvl_reg != LvlW'(StackDepth)) lvl_next = lvl_reg + 1'b1;
		end else if (doPop) begin
			for (int i = 0; i < StackDepth - 1; i++) stack_next[i] = stack_reg[i+1];
			if (lvl_reg != '0) lvl_next = lvl_reg - 1'b1;
		end
		// A request arriving with its clear is kept
		pend_next = (pend_reg & ~(takeAny && !nmiClr && !cmdValid ? hwClr : '0)) | live;
		nmiPend_next = (nmiPend_reg & ~nmiClr) | (nS2_reg & ~nS3_reg);
	end

	// ******************************
	// Registers
	// ******************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{uS1_reg, uS2_reg, uS3_reg} <= 12'h000;
			{nS1_reg, nS2_reg, nS3_reg} <= 3'h0;
			pend_reg <= '0;
			nmiPend_reg <= 1'b0;
			gid_reg <= `DICS_GID_RST;
			vecPtr_reg <= `DICS_PTR_RST;
			stack_reg <= '{default: 16'h0};
			lvl_reg <= '0;
			{rptActive_reg, blkActive_reg} <= 2'h0;
			{rptCount_reg, blkCount_reg, blkStart_reg, blkEnd_reg} <= 64'h0;
			{trap_reg, tUser_reg, pcLd_reg, cond_reg} <= 4'h0;
			tVec_reg <= 5'h00;
			{tAddr_reg, pcAddr_reg, sData_reg} <= 48'h0;
			{sOut_reg, lgV_reg, lgC_reg, rest_reg} <= 4'h0;
			lgVal_reg <= 32'h0;
			shW_reg <= '{default: 32'h0};
			shN_reg <= '{default: 16'h0};
		end else begin
			{uS1_reg, uS2_reg, uS3_reg} <= {uS1_next, uS2_next, uS3_next};
			{nS1_reg, nS2_reg, nS3_reg} <= {nS1_next, nS2_next, nS3_next};
			pend_reg <= pend_next;
			nmiPend_reg <= nmiPend_next;
			gid_reg <= gid_next;
			vecPtr_reg <= vecPtr_next;
			stack_reg <= stack_next;
			lvl_reg <= lvl_next;
			{rptActive_reg, blkActive_reg} <= {rptActive_next, blkActive_next};
			{rptCount_reg, blkCount_reg} <= {rptCount_next, blkCount_next};
			{blkStart_reg, blkEnd_reg} <= {blkStart_next, blkEnd_next};
			{trap_reg, tUser_reg, pcLd_reg, cond_reg} <= {trap_next, tUser_next, pcLd_next, cond_next};
			tVec_reg <= tVec_next;
			{tAddr_reg, pcAddr_reg, sData_reg} <= {tAddr_next, pcAddr_next, sData_next};
			{sOut_reg, lgV_reg, lgC_reg, rest_reg} <= {sOut_next, lgV_next, lgC_next, rest_next};
			lgVal_reg <= lgVal_next;
			shW_reg <= shW_next;
			shN_reg <= shN_next;
		end
	end

	// ******************************
	// Outputs, all straight from flops
	// ******************************
	assign {trapTaken, trapVector, trapAddr, trapUserVector} = {trap_reg, tVec_reg, tAddr_reg, tUser_reg};
	assign {globalIrqDisable, pendingFlags} = {gid_reg, pend_reg};
	assign {pcLoadValid, pcLoadAddr, condTrue} = {pcLd_reg, pcAddr_reg, cond_reg};
	assign {repeatActive, blockActive} = {rptActive_reg, blkActive_reg};
	assign {stackTop, stackLevel} = {stack_reg[0], lvl_reg};
	assign {stackOutValid, stackOutData} = {sOut_reg, sData_reg};
	// Host core writes largerValue into both sum and buffer
	assign {largerValid, largerValue, largerCarry} = {lgV_reg, lgVal_reg, lgC_reg};
	assign restoreValid = rest_reg;
	assign {shadowSum, shadowSumBuf, shadowProduct} = {shW_reg[0], shW_reg[1], shW_reg[2]};
	assign {shadowStatus0, shadowStatus1, shadowMode} = {shN_reg[0], shN_reg[1], shN_reg[2]};
	assign {shadowMulTemp, shadowShiftTemp, shadowBitTemp} = {shN_reg[3], shN_reg[4], shN_reg[5]};
	assign {shadowIndex, shadowCompare} = {shN_reg[6], shN_reg[7]};

	// ******************************
	// Checks
	// ******************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_user_edge_pends: assert property (uS2_reg[0] && !uS3_reg[0] |=> pend_reg[0])
		else $error("user edge not pended");
	a_timer_pends: assert property (timerIrq |=> pend_reg[`DICS_SRC_TIMER])
		else $error("timer request lost");
	a_soft_vector: assert property (cmdValid && cmd == CMD_SOFT_VECTOR |=> trapTaken && trapVector == $past(cmdArg[4:0]))
		else $error("soft vector wrong");
	a_hw_vector_low: assert property (trapTaken && !$past(cmdValid) |-> trapVector < `DICS_RSVD_VEC)
		else $error("hardware vector not reserved");
	a_stack_bound: assert property (stackLevel <= LvlW'(StackDepth))
		else $error("stack level beyond depth");
	a_shadow_save: assert property (cmdValid && cmd == CMD_TRAP |=> shadowSum == $past(ctxSum) && globalIrqDisable)
		else $error("shadow not captured");
	a_irq_return: assert property (cmdValid && (cmd == CMD_IRQ_RET || cmd == CMD_IRQ_RET_EN)
		|=> restoreValid && pcLoadAddr == $past(stackTop))
		else $error("interrupt return wrong");
	a_push_sum: assert property (cmdValid && cmd == CMD_PUSH_SUM |=> stackTop == $past(ctxSum[15:0]))
		else $error("push of sum wrong");
	a_call_push: assert property (cmdValid && cmd == CMD_CALL |=> stackTop == $past(nextPc) && pcLoadValid)
		else $error("call did not push");
	a_keep_larger: assert property (cmdValid && cmd == CMD_KEEP_LARGER
		|=> largerValid && largerCarry == ($signed($past(ctxSum)) > $signed($past(ctxSumBuf))))
		else $error("keep larger carry wrong");
	a_block_loop: assert property (blkActive_reg && execDone && curPc == blkEnd_reg && blkCount_reg != 16'h0
		|=> pcLoadValid && pcLoadAddr == $past(blkStart_reg))
		else $error("block loop missed");
	a_reset_state: assert property ($rose(rst_n) |-> globalIrqDisable && pendingFlags == '0 && vecPtr_reg == 5'h00)
		else $error("reset state wrong");
	a_nmi_taken: assert property (nmiPend_reg && !cmdValid && !rptActive_reg
		|=> trapTaken && trapVector == `DICS_VEC_NMI)
		else $error("nonmaskable not taken");
endmodule
`default_nettype wire

// File: dics_irq_source.sv
// Model of the far-side interrupt pins: four user lines and the nonmaskable line.
// Assumes a one-cycle strobe from the bench; pins are active high with pull-downs.
`timescale 1ns/10ps
`default_nettype none
module dics_irq_source #(
	parameter int HoldCycles = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request strobe, bit 4 is the nonmaskable line
	input wire logic [4:0] fire,
	// Pins
	output logic [3:0] userIrqLines,
	output logic nmiReq
);
	logic [4:0] pinReg;
	logic [3:0] holdReg;
	// Hold a raised line a few cycles so the unit's two-stage synchroniser sees it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinReg <= 5'h00;
			holdReg <= 4'h0;
		end else if (fire != 5'h00) begin
			pinReg <= pinReg | fire;
			holdReg <= 4'(HoldCycles);
		end else if (holdReg != 4'h0) begin
			holdReg <= holdReg - 4'h1;
		end else begin
			pinReg <= 5'h00; // Released lines fall to the pull-down level
		end
	end
	assign userIrqLines = pinReg[3:0];
	assign nmiReq = pinReg[4];
endmodule
`default_nettype wire

// File: dics_exception_unit_bench.sv
// Self-checking bench of the interrupt, context and return-stack unit.
// Assumes the package, the unit and the pin source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dics_exception_unit_bench;
	import dics_pkg::*;
	// ********************
	// Signals
	// ********************
	logic clk, rst_n, cmdValid, execDone, timerIrq, carryIn, overflowIn, testFlagIn, bioIn;
	logic [1:0] serialIrq;
	logic [4:0] fire;
	logic [6:0] irqMask;
	dics_cmd_t cmd;
	logic [15:0] cmdArg, nextPc, curPc, memData, blockRepeatCount;
	logic [12:0] condSel, selNext;
	logic [31:0] ctxSum, ctxSumBuf, ctxProduct;
	logic [15:0] ctxStatus0, ctxStatus1, ctxMode, ctxMulTemp, ctxShiftTemp, ctxBitTemp, ctxIndex, ctxCompare;
	logic [3:0] userIrqLines;
	logic nmiReq;
	logic trapTaken, trapUserVector, globalIrqDisable, pcLoadValid, condTrue, repeatActive, blockActive;
	logic stackOutValid, largerValid, largerCarry, restoreValid;
	logic [4:0] trapVector;
	logic [6:0] pendingFlags;
	logic [15:0] trapAddr, pcLoadAddr, stackTop, stackOutData;
	logic [3:0] stackLevel;
	logic [31:0] largerValue, shadowSum, shadowSumBuf, shadowProduct;
	logic [15:0] shadowStatus0, shadowStatus1, shadowMode, shadowMulTemp, shadowShiftTemp;
	logic [15:0] shadowBitTemp, shadowIndex, shadowCompare;
	int err_total = 0;
	int cmp_count = 0;
	// ********************
	// Instances
	// ********************
	dics_irq_source dics_irq_source_inst (.clk, .rst_n, .fire, .userIrqLines, .nmiReq);
	dics_exception_unit dics_exception_unit_inst (.clk, .rst_n, .userIrqLines, .nmiReq, .serialIrq,
		.timerIrq, .irqMask, .cmdValid, .cmd, .cmdArg, .condSel, .nextPc, .curPc, .execDone, .memData,
		.blockRepeatCount, .carryIn, .overflowIn, .testFlagIn, .bioIn, .ctxSum, .ctxSumBuf, .ctxProduct,
		.ctxStatus0, .ctxStatus1, .ctxMode, .ctxMulTemp, .ctxShiftTemp, .ctxBitTemp, .ctxIndex, .ctxCompare,
		.trapTaken, .trapVector, .trapAddr, .trapUserVector, .globalIrqDisable, .pendingFlags, .pcLoadValid,
		.pcLoadAddr, .condTrue, .repeatActive, .blockActive, .stackTop, .stackLevel, .stackOutValid,
		.stackOutData, .largerValid, .largerValue, .largerCarry, .restoreValid, .shadowSum, .shadowSumBuf,
		.shadowProduct, .shadowStatus0, .shadowStatus1, .shadowMode, .shadowMulTemp, .shadowShiftTemp,
		.shadowBitTemp, .shadowIndex, .shadowCompare);
	// Free-running core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ********************
	// Tasks
	// ********************
	task automatic results();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [223:0] seen, input logic [223:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One command with fresh random context; sum is often zero so the zero tests get exercised
	task automatic cmdGo(input dics_cmd_t c, input logic [15:0] a);
		logic [31:0] s;
		@(posedge clk);
		s = ($urandom % 3 == 0) ? 32'h0 : $urandom;
		cmdValid <= 1'b1;
		cmd <= c;
		cmdArg <= a;
		condSel <= selNext;
		{carryIn, overflowIn, testFlagIn, bioIn} <= 4'($urandom);
		ctxSum <= s;
		ctxSumBuf <= ($urandom % 4 == 0) ? s : $urandom;
		{ctxProduct, nextPc, memData} <= {$urandom, $urandom};
		{ctxStatus0, ctxStatus1, ctxMode, ctxMulTemp} <= {$urandom, $urandom};
		{ctxShiftTemp, ctxBitTemp, ctxIndex, ctxCompare} <= {$urandom, $urandom};
		@(posedge clk);
		cmdValid <= 1'b0;
		#1;
	endtask
	task automatic execPulse(input logic [15:0] pc);
		@(posedge clk);
		execDone <= 1'b1;
		curPc <= pc;
		@(posedge clk);
		execDone <= 1'b0;
		#1;
	endtask
	// Strobe of serial, timer and pin requests for one cycle
	task automatic strobe(input logic [7:0] f);
		@(posedge clk);
		{serialIrq, timerIrq, fire} <= f;
		@(posedge clk);
		{serialIrq, timerIrq, fire} <= 8'h00;
	endtask
	// Bounded wait for a trap entry; a hang ends the run
	task automatic waitTrap(input logic [4:0] vec);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (trapTaken !== 1'b1 && n < 30);
		if (trapTaken !== 1'b1) begin
			err_total++;
			$display("[ERR] trapTaken expected 1 seen timeout");
			results();
		end
		chk("trapVector", trapVector, vec);
	endtask
	// Flags are {carry, overflow, test, bio}; bits follow the condition select map
	function automatic logic condExp(input logic [12:0] sel, input logic signed [31:0] s, input logic [3:0] f);
		logic [12:0] holds;
		holds = {f[1], !f[1], f[0], f[2], !f[2], f[3], !f[3], s >= 0, s > 0, s <= 0, s < 0, s != 0, s == 0};
		return &(~sel | holds);
	endfunction
	// ********************
	// Main sequence
	// ********************
	initial begin
		logic [15:0] t, e, st;
		int n, cnt, loads, k;
		logic bigger, hit;
		rst_n = 1'b0;
		cmd = CMD_NOP;
		irqMask = 7'h7f;
		blockRepeatCount = 16'h0009;
		{cmdValid, execDone, timerIrq, serialIrq, fire, carryIn, overflowIn, testFlagIn, bioIn} = '0;
		{cmdArg, nextPc, curPc, memData, condSel, selNext} = '0;
		{ctxSum, ctxSumBuf, ctxProduct, ctxStatus0, ctxStatus1, ctxMode, ctxMulTemp} = '0;
		{ctxShiftTemp, ctxBitTemp, ctxIndex, ctxCompare} = '0;
		void'($urandom(32'h82a6e1e7));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("resetState", {globalIrqDisable, pendingFlags, stackLevel}, {1'b1, 7'h00, 4'h0});
		// Calls fill the stack past its depth
		for (int i = 0; i < 9; i++) begin
			t = 16'($urandom);
			cmdGo(CMD_CALL, t);
			chk("callJump", {pcLoadValid, pcLoadAddr, stackTop}, {1'b1, t, nextPc});
			chk("stackLevel", stackLevel, (i < 8) ? i + 1 : 8);
		end
		// A false test leaves the stack alone; true and plain returns pop it
		e = nextPc;
		selNext = 13'h0003;
		cmdGo(CMD_COND_RET, 16'h0);
		chk("condRetFalse", {pcLoadValid, stackTop, stackLevel}, {1'b0, e, 4'h8});
		cmdGo(CMD_COND_CALL, 16'h0300);
		chk("condCallFalse", {pcLoadValid, stackTop, stackLevel}, {1'b0, e, 4'h8});
		selNext = 13'h0000;
		cmdGo(CMD_RET, 16'h0);
		chk("plainRet", {pcLoadValid, pcLoadAddr, stackLevel}, {1'b1, e, 4'h7});
		cmdGo(CMD_COND_CALL, 16'h0300);
		e = nextPc;
		chk("condCall", {pcLoadValid, pcLoadAddr, stackTop, stackLevel},
			{1'b1, 16'h0300, e, 4'h8});
		cmdGo(CMD_COND_RET, 16'h0);
		chk("condRet", {pcLoadValid, pcLoadAddr, stackLevel}, {1'b1, e, 4'h7});
		cmdGo(CMD_PUSH_SUM, 16'h0);
		e = ctxSum[15:0];
		chk("pushSum", stackTop, e);
		cmdGo(CMD_POP_SUM, 16'h0);
		chk("popSum", {stackOutValid, stackOutData}, {1'b1, e});
		cmdGo(CMD_MEM_TO_STACK, 16'h0);
		e = memData;
		chk("memToStack", stackTop, e);
		cmdGo(CMD_STACK_TO_MEM, 16'h0);
		chk("stackToMem", {stackOutValid, stackOutData}, {1'b1, e});
		// Every software vector, each followed by one of the two interrupt returns
		for (int v = 0; v < 32; v++) begin
			cmdGo(CMD_SOFT_VECTOR, 16'(v));
			e = nextPc;
			chk("softTrap", {trapTaken, trapVector, trapAddr, trapUserVector},
				{1'b1, 5'(v), 10'h000, 5'(v), 1'b0, v >= 20});
			chk("shadows", {shadowSum, shadowSumBuf, shadowProduct, shadowStatus0, shadowStatus1, shadowMode,
				shadowMulTemp, shadowShiftTemp, shadowBitTemp, shadowIndex, shadowCompare}, {ctxSum, ctxSumBuf,
				ctxProduct, ctxStatus0, ctxStatus1, ctxMode, ctxMulTemp, ctxShiftTemp, ctxBitTemp, ctxIndex,
				ctxCompare});
			cmdGo((v % 2) ? CMD_IRQ_RET_EN : CMD_IRQ_RET, 16'h0);
			chk("irqReturn", {restoreValid, pcLoadValid, pcLoadAddr, globalIrqDisable},
				{2'b11, e, v % 2 == 0});
		end
		// Trap and nonmaskable trigger through a relocated vector table
		cmdGo(CMD_LOAD_VEC_PTR, 16'h0015);
		cmdGo(CMD_TRAP, 16'h0);
		chk("trap", {trapTaken, trapVector, trapAddr, shadowSum, globalIrqDisable},
			{1'b1, 5'h11, 5'h15, 5'h00, 5'h11, 1'b0, ctxSum, 1'b1});
		cmdGo(CMD_NMI_TRIGGER, 16'h0);
		chk("nmiTrigger", {trapTaken, trapVector, trapAddr, stackLevel},
			{1'b1, 5'h12, 5'h15, 5'h00, 5'h12, 1'b0, 4'h8});
		repeat (12) begin
			cmdGo(CMD_KEEP_LARGER, 16'h0);
			bigger = $signed(ctxSum) > $signed(ctxSumBuf);
			chk("keepLarger", {largerValid, largerValue, largerCarry},
				{1'b1, bigger ? ctxSum : ctxSumBuf, bigger});
		end
		// Random combined zero and sign tests, then single tests of any of the thirteen conditions, zero mask meaning always
		for (int i = 0; i < 40; i++) begin
			selNext = (i < 20) ? 13'($urandom % 64) : 13'(1 << ($urandom % 13));
			cmdGo((i % 2) ? CMD_COND_BRANCH : CMD_COND_EXEC, 16'h1234);
			hit = condExp(condSel, ctxSum, {carryIn, overflowIn, testFlagIn, bioIn});
			chk("condTrue", {condTrue, pcLoadValid}, {hit, hit && (i % 2 == 1)});
		end
		n = $urandom % 8;
		cmdGo(CMD_REPEAT_ONE, 16'(n));
		cnt = 0;
		while (repeatActive === 1'b1 && cnt < 20) begin
			execPulse(16'h0);
			cnt++;
		end
		chk("repeatRuns", cnt, n + 1);
		// Block loop; completions off the end address must not loop back
		cmdGo(CMD_REPEAT_BLOCK, 16'h0200);
		st = nextPc;
		cnt = 0;
		loads = 0;
		while (blockActive === 1'b1 && cnt < 30) begin
			execPulse(16'h01ff);
			loads += (pcLoadValid === 1'b1);
			execPulse(16'h0200);
			cnt++;
			if (pcLoadValid === 1'b1) begin
				loads++;
				chk("blockStart", pcLoadAddr, st);
			end
		end
		chk("blockPasses", {cnt, loads}, {32'd10, 32'd9});
		// Pins while disabled stay pending; the nonmaskable line goes through
		cmdGo(CMD_SET_DISABLE, 16'h0);
		k = $urandom % 4;
		strobe(8'(1 << k));
		repeat (8) @(posedge clk);
		#1;
		chk("heldPending", {trapTaken, pendingFlags}, {1'b0, 7'(1 << k)});
		// Masks hold back the user line but never the nonmaskable one
		@(posedge clk);
		irqMask <= 7'h00;
		strobe(8'h10);
		waitTrap(5'h12);
		cmdGo(CMD_CLR_DISABLE, 16'h0);
		repeat (3) @(posedge clk);
		#1;
		chk("maskedHeld", {trapTaken, globalIrqDisable, pendingFlags}, {2'b00, 7'(1 << k)});
		@(posedge clk);
		irqMask <= 7'h7f;
		waitTrap(5'(1 + k));
		cmdGo(CMD_IRQ_RET_EN, 16'h0);
		strobe(8'h20);
		waitTrap(5'h05);
		cmdGo(CMD_IRQ_RET_EN, 16'h0);
		strobe(8'h40);
		waitTrap(5'h06);
		results();
	end
endmodule
`default_nettype wire
